// ### src/port_expander_params.svh
// constants for the i2c sixteen bit port expander
// assumes inclusion by bare name from the package and the design files
`ifndef PORT_EXPANDER_PARAMS_SVH
`define PORT_EXPANDER_PARAMS_SVH
// ****************************************************************
// address byte layout
// ****************************************************************
`define ADDR_FIXED_NIBBLE 4'h4
`define ADDR_NIBBLE_MSB 7
`define ADDR_NIBBLE_LSB 4
`define ADDR_SEL_MSB 3
`define ADDR_SEL_LSB 1
`define ADDR_RW_BIT 0
// ****************************************************************
// reset values
// ****************************************************************
`define PORT_LATCH_RESET 16'hffff
`define SHIFT_RESET 8'h00
// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 5
`define INT_VALID_NS 4000
`define INT_VALID_CYC ((`INT_VALID_NS) / (`CLK_PERIOD_NS))
`endif

// ### src/port_expander_pkg.sv
// types shared by the port expander design files
// assumes the params header sits in the include path
`include "port_expander_params.svh"
package port_expander_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ = 3'b100,
        ST_RACK = 3'b101,
        ST_SKIP = 3'b110
    } bus_state_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } port_word_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } bus_event_t;
endpackage : port_expander_pkg

// ### src/bus_line_sync.sv
// two-flop synchroniser for bus lines plus condition detection
// assumes scl and sda arrive asynchronously from the pins
`timescale 1ns/1ps
module bus_line_sync
    import port_expander_pkg::*;
(
    // clock
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // raw lines
    input wire logic scl_in,
    input wire logic sda_in,
    // filtered view
    output logic sda_level,
    output bus_event_t events
);
    logic [1:0] scl_meta_r;
    logic [1:0] sda_meta_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic rise_w;
    logic fall_w;
    logic start_w;
    logic stop_w;

    // first stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (reset) begin
            scl_meta_r <= 2'h3;
            sda_meta_r <= 2'h3;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else if (clk_en) begin
            scl_meta_r <= {scl_meta_r[0], scl_in};
            sda_meta_r <= {sda_meta_r[0], sda_in};
            scl_prev_r <= scl_meta_r[1];
            sda_prev_r <= sda_meta_r[1];
        end
    end

    assign sda_level = sda_meta_r[1];
    assign rise_w = clk_en & ~scl_prev_r & scl_meta_r[1];
    assign fall_w = clk_en & scl_prev_r & ~scl_meta_r[1];
    assign start_w = clk_en & scl_meta_r[1] & scl_prev_r & sda_prev_r & ~sda_meta_r[1];
    assign stop_w = clk_en & scl_meta_r[1] & scl_prev_r & ~sda_prev_r & sda_meta_r[1];
    // one driver for the whole struct keeps strict tools happy
    assign events = '{start: start_w, stop: stop_w, rise: rise_w, fall: fall_w};
endmodule : bus_line_sync

// ### src/port_expander.sv
// i2c slave core of a sixteen line quasi-bidirectional port expander
// assumes scl, sda, strap and port pins come straight from the package pins
`timescale 1ns/1ps
`include "port_expander_params.svh"
module port_expander
    import port_expander_pkg::*;
(
    // clock and power-on reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // address straps
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0,
    // port lines, quasi-bidirectional: drive low or release
    input wire logic [7:0] low_port_lines,
    input wire logic [7:0] high_port_lines,
    output port_word_t port_latch,
    // open-drain interrupt
    output logic int_n_out,
    output logic int_n_oe_n
);
    // ****************************************************************
    // synchronisers
    // ****************************************************************
    logic sda_level;
    bus_event_t ev;
    logic [15:0] pin_meta_r;
    logic [15:0] pin_sync_r;
    logic [2:0] sel_meta_r;
    logic [2:0] sel_sync_r;

    bus_line_sync u_sync (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_level(sda_level),
        .events(ev)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_meta_r <= 16'hffff;
            pin_sync_r <= 16'hffff;
            sel_meta_r <= 3'h0;
            sel_sync_r <= 3'h0;
        end else if (clk_en) begin
            pin_meta_r <= {high_port_lines, low_port_lines};
            pin_sync_r <= pin_meta_r;
            sel_meta_r <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
            sel_sync_r <= sel_meta_r;
        end
    end

    // ****************************************************************
    // address match
    // ****************************************************************
    function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] sel);
        addr_hit = (b[`ADDR_NIBBLE_MSB:`ADDR_NIBBLE_LSB] == `ADDR_FIXED_NIBBLE)
            && (b[`ADDR_SEL_MSB:`ADDR_SEL_LSB] == sel);
    endfunction : addr_hit

    // ****************************************************************
    // bus state machine
    // ****************************************************************
    bus_state_t state_r;
    logic [7:0] shift_r;
    logic [3:0] bit_r;
    logic rw_r;
    logic half_r;
    logic pair_ack_r;
    logic [7:0] low_hold_r;
    port_word_t latch_r;
    logic [15:0] snap_r;
    logic sda_drive_low_r;
    logic ack_clear;

    assign ack_clear = ev.rise && (state_r == ST_ACK || state_r == ST_RACK);

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            shift_r <= `SHIFT_RESET;
            bit_r <= 4'h0;
            rw_r <= 1'b0;
            half_r <= 1'b0;
            low_hold_r <= 8'hff;
            pair_ack_r <= 1'b0;
        end else if (clk_en) begin
            if (ev.start) begin
                state_r <= ST_ADDR;
                bit_r <= 4'h0;
                half_r <= 1'b0;
            end else if (ev.stop) begin
                state_r <= ST_IDLE;
            end else begin
                unique case (state_r)
                    ST_IDLE, ST_SKIP: begin
                    end
                    ST_ADDR, ST_WRITE: begin
                        if (ev.rise) begin
                            shift_r <= {shift_r[6:0], sda_level};
                            bit_r <= bit_r + 4'h1;
                        end else if (ev.fall && bit_r == 4'h8) begin
                            bit_r <= 4'h0;
                            // address ack also lands in ST_ACK, so mark the second data byte
                            pair_ack_r <= (state_r == ST_WRITE) && half_r;
                            if (state_r == ST_ADDR) begin
                                // general call 00h never matches the fixed nibble
                                if (addr_hit(shift_r, sel_sync_r)) begin
                                    rw_r <= shift_r[`ADDR_RW_BIT];
                                    state_r <= ST_ACK;
                                end else begin
                                    state_r <= ST_SKIP;
                                end
                            end else begin
                                if (!half_r) begin
                                    low_hold_r <= shift_r;
                                end
                                half_r <= ~half_r;
                                state_r <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (ev.fall) begin
                            state_r <= rw_r ? ST_READ : ST_WRITE;
                            if (rw_r) begin
                                shift_r <= half_r ? snap_r[15:8] : snap_r[7:0];
                            end
                        end
                    end
                    ST_READ: begin
                        if (ev.fall) begin
                            shift_r <= {shift_r[6:0], 1'b1};
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == 4'h7) begin
                                bit_r <= 4'h0;
                                state_r <= ST_RACK;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (ev.rise) begin
                            // master nack ends the read
                            half_r <= ~half_r;
                            if (sda_level) begin
                                state_r <= ST_SKIP;
                            end
                        end else if (ev.fall) begin
                            state_r <= ST_READ;
                            shift_r <= half_r ? snap_r[15:8] : snap_r[7:0];
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // pins sampled at the acknowledge that precedes each read pair
    always_ff @(posedge mclk) begin
        if (reset) begin
            snap_r <= 16'hffff;
        end else if (clk_en && ack_clear && (state_r == ST_ACK ? !half_r : half_r)) begin
            snap_r <= pin_sync_r;
        end
    end

    // ****************************************************************
    // output latches, updated only after a full pair is acknowledged
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            latch_r <= `PORT_LATCH_RESET;
        end else if (clk_en && ev.rise && state_r == ST_ACK && !rw_r && pair_ack_r) begin
            latch_r <= {shift_r, low_hold_r};
        end
    end
    assign port_latch = latch_r;

    // ****************************************************************
    // sda drive: ack in write/address, data bit in read
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            sda_drive_low_r <= 1'b0;
        end else if (clk_en) begin
            if (ev.start || ev.stop) begin
                sda_drive_low_r <= 1'b0;
            end else if (ev.fall) begin
                if (state_r == ST_ADDR && bit_r == 4'h8) begin
                    sda_drive_low_r <= addr_hit(shift_r, sel_sync_r);
                end else if (state_r == ST_WRITE && bit_r == 4'h8) begin
                    sda_drive_low_r <= 1'b1;
                end else if (state_r == ST_ACK && rw_r) begin
                    sda_drive_low_r <= ~(half_r ? snap_r[15] : snap_r[7]);
                end else if (state_r == ST_READ && bit_r != 4'h7) begin
                    sda_drive_low_r <= ~shift_r[6];
                end else if (state_r == ST_RACK) begin
                    sda_drive_low_r <= ~(half_r ? snap_r[15] : snap_r[7]) & ~sda_level;
                end else begin
                    sda_drive_low_r <= 1'b0;
                end
            end
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe_n = ~sda_drive_low_r;

    // ****************************************************************
    // interrupt: compare input-mode lines to the reference value
    // ****************************************************************
    logic [15:0] ref_r;
    logic int_r;
    logic [15:0] diff;
    // only released-high lines are inputs; driven-low lines cannot change
    assign diff = (pin_sync_r ^ ref_r) & latch_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            ref_r <= 16'hffff;
            int_r <= 1'b0;
        end else if (clk_en) begin
            if (ack_clear) begin
                ref_r <= pin_sync_r;
                int_r <= 1'b0;
            end else begin
                int_r <= |diff;
            end
        end
    end
    assign int_n_out = 1'b0;
    assign int_n_oe_n = ~int_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    int_clear_a: assert property (@(posedge mclk) disable iff (reset)
        clk_en && ack_clear |=> !int_r)
        else $error("interrupt not cleared at ack");
    latch_reset_a: assert property (@(posedge mclk)
        reset |=> port_latch == 16'hffff)
        else $error("latch not released after reset");
    state_reset_a: assert property (@(posedge mclk)
        reset |=> state_r == ST_IDLE)
        else $error("bus machine not idle after reset");
    bad_addr_a: assert property (@(posedge mclk) disable iff (reset)
        clk_en && ev.fall && state_r == ST_ADDR && bit_r == 4'h8
        && shift_r[7:4] != 4'h4 |=> state_r == ST_SKIP && sda_oe_n)
        else $error("foreign address acknowledged");
    good_addr_a: assert property (@(posedge mclk) disable iff (reset)
        clk_en && ev.fall && state_r == ST_ADDR && bit_r == 4'h8 && !ev.start
        && !ev.stop && shift_r[7:1] == {4'h4, sel_sync_r} |=> !sda_oe_n)
        else $error("own address not acknowledged");
    pair_write_a: assert property (@(posedge mclk) disable iff (reset)
        $changed(port_latch) |-> $past(pair_ack_r) && $past(ev.rise) && $past(state_r) == ST_ACK)
        else $error("latch changed mid pair");
    read_src_a: assert property (@(posedge mclk) disable iff (reset)
        clk_en && ev.fall && state_r == ST_ACK && rw_r && !half_r && !ev.start
        && !ev.stop |=> shift_r == snap_r[7:0])
        else $error("read byte not from port 0");
    int_set_a: assert property (@(posedge mclk) disable iff (reset)
        clk_en && !ack_clear && |diff |=> !int_n_oe_n)
        else $error("input edge missed");
endmodule : port_expander

// ### verif/i2c_master_model.sv
// bus master model that clocks the expander's serial lines
// assumes the bench forms the sda wire from sda_rel and the device drive
`timescale 1ns/1ps
module i2c_master_model (
    // clock
    input wire logic mclk,
    // bus
    input wire logic sda_line,
    output logic scl,
    output logic sda_rel
);
    // ****************
    // bit timing
    // ****************
    // eight mclk a quarter bit, twice what the device sampler needs
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic tick();
        repeat (8) @(posedge mclk);
        #1;
    endtask : tick
    task automatic start();
        sda_rel = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_rel = 1'b0;
        tick();
        scl = 1'b0;
        tick();
    endtask : start
    task automatic stop();
        sda_rel = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_rel = 1'b1;
        tick();
    endtask : stop
    // sda only moves while scl is low, with a quarter bit of hold
    task automatic bit_io(input logic b, output logic s);
        sda_rel = b;
        tick();
        scl = 1'b1;
        tick();
        s = sda_line;
        tick();
        scl = 1'b0;
        tick();
    endtask : bit_io
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : write_byte
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, s);
    endtask : read_byte
endmodule : i2c_master_model

// ### verif/port_expander_tb_top.sv
// self-checking bench for the port expander slave core
// assumes pull-ups on sda, the interrupt line and every port line
`timescale 1ns/1ps
`include "port_expander_params.svh"
module port_expander_tb_top;
    import port_expander_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] strap = 3'h0;
    logic en = 1'b1;
    logic [7:0] ext_low = 8'hff;
    logic [7:0] ext_high = 8'hff;
    logic scl, sda_rel, sda_out, sda_oe_n, int_n_out, int_n_oe_n, ack;
    logic [7:0] rd;
    port_word_t port_latch;
    wire sda_line = sda_rel & sda_oe_n;
    int fail_count = 0;
    int cmp_count = 0;
    always #2.5 mclk = ~mclk;
    // ****************
    // structure
    // ****************
    i2c_master_model m_u (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
    // a pin reads low if the latch or the outside pulls it low
    port_expander dut_u (.mclk(mclk), .reset(reset), .clk_en(en), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_select_bit2(strap[2]), .addr_select_bit1(strap[1]),
        .addr_select_bit0(strap[0]), .low_port_lines(port_latch.low & ext_low),
        .high_port_lines(port_latch.high & ext_high), .port_latch(port_latch),
        .int_n_out(int_n_out), .int_n_oe_n(int_n_oe_n));
    // ****************
    // helpers
    // ****************
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic send(input logic [7:0] d, input logic e);
        m_u.write_byte(d, ack);
        chk_bit("ack", e, ack);
    endtask : send
    task automatic fetch(input logic nack, input logic [7:0] e);
        m_u.read_byte(nack, rd);
        chk_word("read", {8'h00, e}, {8'h00, rd});
    endtask : fetch
    task automatic wait_int(input logic lvl);
        for (int i = 0; i < `INT_VALID_CYC && int_n_oe_n !== lvl; i++) begin
            @(posedge mclk);
            #1;
        end
        #1;
        chk_bit("int", lvl, int_n_oe_n);
    endtask : wait_int
    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        chk_word("latch", 16'hffff, port_latch);
        chk_bit("int", 1'b1, int_n_oe_n);
        chk_bit("sda", 1'b1, sda_oe_n);
    endtask : t_reset
    task automatic t_straps();
        for (int s = 0; s < 8; s++) begin
            strap = s[2:0];
            m_u.start();
            send({4'h4, strap, 1'b0}, 1'b1);
            send(8'h01 << s, 1'b1);
            send(8'h80 >> s, 1'b1);
            m_u.stop();
            chk_word("latch", {8'h80 >> s, 8'h01 << s}, port_latch);
            m_u.start();
            send({4'h4, strap, 1'b0} + 8'h01, 1'b1);
            fetch(1'b0, 8'h01 << s);
            fetch(1'b1, 8'h80 >> s);
            m_u.stop();
            m_u.start();
            send({4'h4, strap + 3'h1, 1'b0}, 1'b0);
            m_u.stop();
        end
    endtask : t_straps
    task automatic t_pairs();
        m_u.start();
        send(8'h00, 1'b0);
        m_u.stop();
        m_u.start();
        send(8'h4e, 1'b1);
        send(8'ha1, 1'b1);
        send(8'hb2, 1'b1);
        send(8'hc3, 1'b1);
        send(8'hd4, 1'b1);
        send(8'he5, 1'b1);
        m_u.stop();
        chk_word("latch", 16'hd4c3, port_latch);
        m_u.start();
        send(8'h4e, 1'b1);
        send(8'hff, 1'b1);
        send(8'hff, 1'b1);
        m_u.stop();
        ext_low = 8'h5a;
        ext_high = 8'hc3;
        m_u.start();
        send(8'h4f, 1'b1);
        fetch(1'b0, 8'h5a);
        fetch(1'b1, 8'hc3);
        m_u.stop();
        ext_low = 8'hff;
        ext_high = 8'hff;
    endtask : t_pairs
    // restoring the pins after the pair test leaves an edge pending, cleared by a write
    task automatic t_int();
        wait_int(1'b0);
        m_u.start();
        send(8'h4e, 1'b1);
        chk_bit("int", 1'b1, int_n_oe_n);
        send(8'hff, 1'b1);
        send(8'hff, 1'b1);
        m_u.stop();
        wait_int(1'b1);
        ext_low[3] = 1'b0;
        wait_int(1'b0);
        ext_low[3] = 1'b1;
        wait_int(1'b1);
        ext_high[6] = 1'b0;
        wait_int(1'b0);
        m_u.start();
        send(8'h4f, 1'b1);
        chk_bit("int", 1'b1, int_n_oe_n);
        fetch(1'b0, 8'hff);
        fetch(1'b1, 8'hbf);
        m_u.stop();
        ext_high[6] = 1'b1;
    endtask : t_int
    // with the enable low a whole frame must pass unseen
    task automatic t_freeze();
        en = 1'b0;
        m_u.start();
        send(8'h4e, 1'b0);
        m_u.stop();
        en = 1'b1;
        chk_word("latch", 16'hffff, port_latch);
    endtask : t_freeze
    task automatic t_rereset();
        m_u.start();
        send(8'h4e, 1'b1);
        send(8'h12, 1'b1);
        send(8'h34, 1'b1);
        m_u.stop();
        chk_word("latch", 16'h3412, port_latch);
        reset = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        t_reset();
    endtask : t_rereset
    // ****************
    // run control
    // ****************
    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (80000) @(posedge mclk);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        t_reset();
        t_straps();
        t_pairs();
        t_int();
        t_freeze();
        t_rereset();
        end_sim();
    end
endmodule : port_expander_tb_top
